// File: design/acpcr_regs.sv
// Clock and power configuration register bank with its control outputs.
// Assumes a synchronous byte register port decoded from the serial link.
`timescale 1ns/1ps
`include "acpcr_cfg.svh"
module acpcr_regs
    import acpcr_pkg::*;
#(
    parameter int POS_WIDTH = 24
) (
    // Clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 rstn_i,
    // Register port
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [7:0]           reg_wdata_i,
    output logic      [7:0]           reg_rdata_o,
    // SYSREF windowing
    input  wire logic                 pos_valid_i,
    input  wire logic [POS_WIDTH-1:0] pos_value_i,
    input  wire logic [3:0]           sysref_delay_select_i,
    output logic      [3:0]           capture_delay_o,
    // Analog controls
    output logic      [15:0]          full_scale_setting_o,
    output logic      [7:0]           power_profile_code_o,
    output acpcr_profile_t            power_profile_o,
    output logic                      timestamp_receiver_enable_o,
    output logic                      timestamp_pecl_termination_o,
    // Reference clock output
    input  wire logic                 pll_enable_i,
    output logic                      reference_clock_output_en_o
);
    // Read mux slices the position word into exactly three bytes
    if (POS_WIDTH != 24) begin : g_pos_width_check
        $error("acpcr_regs: POS_WIDTH must be 24");
    end

    // Reset image of the full-scale pair, split into its two bytes below
    localparam logic [15:0] FS_RESET = `ACPCR_RST_FS;

    // Stored register bytes
    logic [7:0]           fs_lo_r;
    logic [7:0]           fs_hi_r;
    logic [7:0]           prof_r;
    logic [7:0]           timestamp_input_r;
    logic [7:0]           refo_r;
    logic [7:0]           rdata_r;
    logic [3:0]           dly_r;
    acpcr_profile_t       profile_r;

    // Next values of the stored bytes
    logic [7:0]           fs_lo_nxt;
    logic [7:0]           fs_hi_nxt;
    logic [7:0]           prof_nxt;
    logic [7:0]           timestamp_input_nxt;
    logic [7:0]           refo_nxt;
    logic [7:0]           rdata_nxt;
    acpcr_profile_t       profile_nxt;

    // Captured position word and the selected read byte
    logic [POS_WIDTH-1:0] pos_w;
    logic [7:0]           rd_mux;

    // Address match, shared by the write strobes and the read mux
    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction

    // Byte that a write strobe replaces, or keeps when idle
    function automatic logic [7:0] byte_update(input logic [7:0] old_val,
                                               input logic [7:0] new_val,
                                               input logic       wr_en);
        byte_update = wr_en ? new_val : old_val;
    endfunction

    // Byte gated onto the read mux only when its address hits
    function automatic logic [7:0] byte_select(input logic       sel,
                                               input logic [7:0] val);
        byte_select = {8{sel}} & val;
    endfunction

    // Codes other than the two defined ones decode as reserved
    function automatic acpcr_profile_t decode_profile(input logic [7:0] code);
        if (code == `ACPCR_PROF_LOW) begin
            decode_profile = ACPCR_PROF_LOW_POWER;
        end else if (code == `ACPCR_PROF_HIGH) begin
            decode_profile = ACPCR_PROF_HIGH_PERF;
        end else begin
            decode_profile = ACPCR_PROF_RESERVED;
        end
    endfunction

    acpcr_pos_hold #(
        .WIDTH (POS_WIDTH)
    ) u_pos (
        .core_clk_i  (core_clk_i),
        .rstn_i      (rstn_i),
        .cap_valid_i (pos_valid_i),
        .cap_pos_i   (pos_value_i),
        .pos_o       (pos_w)
    );

    // One hit per mapped byte; unmapped addresses hit nothing and read as zero
    wire hit_pos0  = addr_hit(reg_addr_i, `ACPCR_ADDR_POS0);
    wire hit_pos1  = addr_hit(reg_addr_i, `ACPCR_ADDR_POS1);
    wire hit_pos2  = addr_hit(reg_addr_i, `ACPCR_ADDR_POS2);
    wire hit_fs_lo = addr_hit(reg_addr_i, `ACPCR_ADDR_FS_LO);
    wire hit_fs_hi = addr_hit(reg_addr_i, `ACPCR_ADDR_FS_HI);
    wire hit_prof  = addr_hit(reg_addr_i, `ACPCR_ADDR_PROF1);
    wire hit_timestamp_input = addr_hit(reg_addr_i, `ACPCR_ADDR_TIMESTAMP_INPUT);
    wire hit_refo  = addr_hit(reg_addr_i, `ACPCR_ADDR_REFO);

    // Write strobes; the position bytes get none, so writes there fall away
    wire wr_fs_lo  = reg_wr_i && hit_fs_lo;
    wire wr_fs_hi  = reg_wr_i && hit_fs_hi;
    wire wr_prof   = reg_wr_i && hit_prof;
    wire wr_timestamp_input  = reg_wr_i && hit_timestamp_input;
    wire wr_refo   = reg_wr_i && hit_refo;

    // Status bytes are only ever selected here, never written
    assign rd_mux = byte_select(hit_pos0,  pos_w[7:0])      // [R1]
                  | byte_select(hit_pos1,  pos_w[15:8])     // [R1]
                  | byte_select(hit_pos2,  pos_w[23:16])    // [R1]
                  | byte_select(hit_fs_lo, fs_lo_r)
                  | byte_select(hit_fs_hi, fs_hi_r)
                  | byte_select(hit_prof,  prof_r)
                  | byte_select(hit_timestamp_input, timestamp_input_r)
                  | byte_select(hit_refo,  refo_r);

    // Next values
    assign fs_lo_nxt   = byte_update(fs_lo_r, reg_wdata_i, wr_fs_lo);
    assign fs_hi_nxt   = byte_update(fs_hi_r, reg_wdata_i, wr_fs_hi);
    assign prof_nxt    = byte_update(prof_r,  reg_wdata_i, wr_prof);
    assign timestamp_input_nxt   = byte_update(timestamp_input_r, reg_wdata_i, wr_timestamp_input);
    assign refo_nxt    = byte_update(refo_r,  reg_wdata_i, wr_refo);
    assign rdata_nxt   = reg_rd_i ? rd_mux : rdata_r;
    assign profile_nxt = decode_profile(prof_nxt); // [R6]

    // Full-scale bytes land one at a time; between the two a mixed code stands
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fs_lo_r <= FS_RESET[7:0]; // [R4]
        end else begin
            fs_lo_r <= fs_lo_nxt;
        end
    end

    // High byte of the shared full-scale code
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fs_hi_r <= FS_RESET[15:8]; // [R4]
        end else begin
            fs_hi_r <= fs_hi_nxt;
        end
    end

    // Profile code is stored as written; reserved codes are not refused
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prof_r <= `ACPCR_RST_PROF1; // [R6]
        end else begin
            prof_r <= prof_nxt;
        end
    end

    // Timestamp receiver and termination bits; reserved bits read back
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timestamp_input_r <= `ACPCR_RST_TIMESTAMP_INPUT; // [R11] [R12]
        end else begin
            timestamp_input_r <= timestamp_input_nxt;
        end
    end

    // Enable comes up set so the reference clock runs before any host access while pll_enable_i is high
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            refo_r <= `ACPCR_RST_REFO; // [R14]
        end else begin
            refo_r <= refo_nxt;
        end
    end

    // Decoded profile changes in the same cycle as the stored code
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            profile_r <= ACPCR_PROF_HIGH_PERF; // [R6]
        end else begin
            profile_r <= profile_nxt;
        end
    end

    // Read data holds until the next read
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // One-cycle copy of the neighbouring delay select
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dly_r <= 4'h0;
        end else begin
            dly_r <= sysref_delay_select_i; // [R3]
        end
    end

    // Output levels
    assign reg_rdata_o                  = rdata_r;
    assign capture_delay_o              = dly_r;
    assign full_scale_setting_o         = {fs_hi_r, fs_lo_r}; // [R4]
    assign power_profile_code_o         = prof_r;
    assign power_profile_o              = profile_r; // [R6]
    assign timestamp_receiver_enable_o  = timestamp_input_r[`ACPCR_TIMESTAMP_INPUT_RECV]; // [R11]
    assign timestamp_pecl_termination_o = timestamp_input_r[`ACPCR_TIMESTAMP_INPUT_PECL]; // [R12]
    assign reference_clock_output_en_o  = refo_r[`ACPCR_REFO_EN] & pll_enable_i; // [R13]
endmodule

// File: include/acpcr_cfg.svh
// Constants for the clock and power configuration register bank.
// Assumes a byte-wide register port with byte addresses.
//
// Contract
// R1 - Read-only 24-bit SYSREF edge position status
// R2 - Host uses position status to pick delay
// R3 - Four-bit delay select chooses capture delay
// R4 - Full-scale setting 16 bits, reset 0xa000
// R5 - Host keeps full-scale at or above 0x2000
// R6 - Profile 0x46 low power, 0x4b high performance
// R7 - Host writes only the two profile codes
// R8 - Host programs all four power registers together
// R9 - Host clears calibration and link before change
// R10 - Host calibrates after any profile change
// R11 - Timestamp bit 0 enables receiver, reset 0
// R12 - Timestamp bit 1 selects PECL termination
// R13 - Reference output driven when enable and PLL
// R14 - Reference output enable resets to one
// R15 - Host writes reserved bits with defaults
// R16 - Writes to position status are ignored
`ifndef ACPCR_CFG_SVH
`define ACPCR_CFG_SVH
`define ACPCR_ADDR_POS0     8'h2c
`define ACPCR_ADDR_POS1     8'h2d
`define ACPCR_ADDR_POS2     8'h2e
`define ACPCR_ADDR_FS_LO    8'h30
`define ACPCR_ADDR_FS_HI    8'h31
`define ACPCR_ADDR_PROF1    8'h37
`define ACPCR_ADDR_TIMESTAMP_INPUT    8'h3b
`define ACPCR_ADDR_REFO     8'h3c
`define ACPCR_RST_FS        16'ha000
`define ACPCR_RST_PROF1     8'h4b
`define ACPCR_RST_TIMESTAMP_INPUT     8'h00
`define ACPCR_RST_REFO      8'h01
`define ACPCR_PROF_LOW      8'h46
`define ACPCR_PROF_HIGH     8'h4b
`define ACPCR_TIMESTAMP_INPUT_RECV    0
`define ACPCR_TIMESTAMP_INPUT_PECL    1
`define ACPCR_REFO_EN       0
`endif

// File: include/acpcr_pkg.sv
// Types for the clock and power configuration register bank.
// Assumes nothing of its surroundings.
package acpcr_pkg;
    typedef enum logic [1:0] {
        ACPCR_PROF_HIGH_PERF,
        ACPCR_PROF_LOW_POWER,
        ACPCR_PROF_RESERVED
    } acpcr_profile_t;
endpackage

// File: design/acpcr_pos_hold.sv
// Holds the captured SYSREF edge position word.
// Assumes the capture strobe comes from the windowing logic.
`timescale 1ns/1ps
module acpcr_pos_hold #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rstn_i,
    // Capture side
    input  wire logic             cap_valid_i,
    input  wire logic [WIDTH-1:0] cap_pos_i,
    // Read side
    output logic      [WIDTH-1:0] pos_o
);
    if (WIDTH < 1 || WIDTH > 32) begin : g_width_check
        $error("acpcr_pos_hold: WIDTH out of range");
    end

    logic [WIDTH-1:0] pos_r;

    // Only the capture strobe updates; bus writes never reach here
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pos_r <= '0;
        end else if (cap_valid_i) begin
            pos_r <= cap_pos_i; // [R1] [R16]
        end
    end

    assign pos_o = pos_r;
endmodule

// File: dv/acpcr_regs_chk.sv
// Port assertions for the register bank.
// Assumes a bind onto acpcr_regs.
`timescale 1ns/1ps
module acpcr_regs_chk (
    input wire logic        core_clk_i,
    input wire logic        rstn_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [15:0] full_scale_setting_o,
    input wire logic [7:0]  power_profile_code_o,
    input wire logic [1:0]  power_profile_o,
    input wire logic        pll_enable_i,
    input wire logic        reference_clock_output_en_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    wire [7:0]  wa = reg_wr_i ? reg_addr_i : 8'h00;
    wire [7:0]  wd = reg_wdata_i;
    wire [15:0] fs = full_scale_setting_o;
    wire        ro = reference_clock_output_en_o;
    property p_fs_rst; $rose(rstn_i) |-> fs == 16'ha000; endproperty
    sequence s_fs_lo_wr; wa == 8'h30; endsequence
    sequence s_fs_hi_wr; wa == 8'h31; endsequence
    sequence s_pf_wr; wa == 8'h37; endsequence
    sequence s_ro_clr; wa == 8'h3c && !wd[0]; endsequence
    property p_fs_lo; s_fs_lo_wr |=> fs[7:0] == $past(wd); endproperty
    property p_fs_hi; s_fs_hi_wr |=> fs[15:8] == $past(wd); endproperty
    property p_pf_rst; $rose(rstn_i) |-> power_profile_code_o == 8'h4b; endproperty
    property p_pf_wr; s_pf_wr |=> power_profile_code_o == $past(wd); endproperty
    property p_pf_low;
        power_profile_code_o == 8'h46 |-> power_profile_o == acpcr_pkg::ACPCR_PROF_LOW_POWER;
    endproperty
    property p_pf_high;
        power_profile_code_o == 8'h4b |-> power_profile_o == acpcr_pkg::ACPCR_PROF_HIGH_PERF;
    endproperty
    property p_ro_rst; $rose(rstn_i) |-> ro == pll_enable_i; endproperty
    property p_ro_pll; !pll_enable_i |-> !ro; endproperty
    property p_ro_off; s_ro_clr |=> !ro; endproperty
    a_fs_rst: assert property (p_fs_rst) else $error("fs reset");
    a_fs_lo: assert property (p_fs_lo) else $error("fs low");
    a_fs_hi: assert property (p_fs_hi) else $error("fs high");
    a_pf_rst: assert property (p_pf_rst) else $error("profile reset");
    a_pf_wr: assert property (p_pf_wr) else $error("profile write");
    a_pf_low: assert property (p_pf_low) else $error("profile low decode");
    a_pf_high: assert property (p_pf_high) else $error("profile high decode");
    a_ro_rst: assert property (p_ro_rst) else $error("refo reset");
    a_ro_pll: assert property (p_ro_pll) else $error("refo pll");
    a_ro_off: assert property (p_ro_off) else $error("refo off");
endmodule
bind acpcr_regs acpcr_regs_chk u_chk (
    .core_clk_i                  (core_clk_i),
    .rstn_i                      (rstn_i),
    .reg_wr_i                    (reg_wr_i),
    .reg_addr_i                  (reg_addr_i),
    .reg_wdata_i                 (reg_wdata_i),
    .full_scale_setting_o        (full_scale_setting_o),
    .power_profile_code_o        (power_profile_code_o),
    .power_profile_o             (power_profile_o),
    .pll_enable_i                (pll_enable_i),
    .reference_clock_output_en_o (reference_clock_output_en_o)
);

// File: dv/acpcr_host.sv
// Host model on the register port.
// Assumes requests launch on falling edges.
`timescale 1ns/1ps
module acpcr_host (
    input  wire logic       core_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic            reg_wr_o = 0,
    output logic            reg_rd_o = 0,
    output logic [7:0]      reg_addr_o = 0,
    output logic [7:0]      reg_wdata_o = 0
);
    task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge core_clk_i);
        case (a)
            8'h31: d = d | 8'h20;
            // Companion power registers, calibration and link enable sit outside
            // this bank; they are taken as idle, with a calibration after each change
            8'h37: d = d[0] ? 8'h46 : 8'h4b;
            8'h3b: d = d & 8'h03;
            8'h3c: d = d & 8'h01;
            default: ;
        endcase
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
        @(negedge core_clk_i);
        q = w ? d : reg_rdata_i;
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
    endtask
endmodule

// File: dv/tb_adc_clock_power_config_regs.sv
// Random host traffic against an integer model.
// Assumes host model and checker compiled first.
`timescale 1ns/1ps
module tb_adc_clock_power_config_regs;
    import acpcr_pkg::*;
    logic        core_clk_i = 0, rstn_i = 0, pos_valid_i = 0, pll_enable_i = 1;
    logic [23:0] pos_value_i = 0;
    logic [3:0]  sysref_delay_select_i = 0;
    logic [7:0]  q;
    wire         reg_wr_i, reg_rd_i, reference_clock_output_en_o;
    wire         timestamp_receiver_enable_o, timestamp_pecl_termination_o;
    wire  [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, power_profile_code_o;
    wire  [3:0]  capture_delay_o;
    wire  [15:0] full_scale_setting_o;
    acpcr_pkg::acpcr_profile_t power_profile_o;
    int          errors = 0, comparisons = 0, m[int];
    acpcr_regs dut (
        .core_clk_i                   (core_clk_i),
        .rstn_i                       (rstn_i),
        .reg_wr_i                     (reg_wr_i),
        .reg_rd_i                     (reg_rd_i),
        .reg_addr_i                   (reg_addr_i),
        .reg_wdata_i                  (reg_wdata_i),
        .reg_rdata_o                  (reg_rdata_o),
        .pos_valid_i                  (pos_valid_i),
        .pos_value_i                  (pos_value_i),
        .sysref_delay_select_i        (sysref_delay_select_i),
        .capture_delay_o              (capture_delay_o),
        .full_scale_setting_o         (full_scale_setting_o),
        .power_profile_code_o         (power_profile_code_o),
        .power_profile_o              (power_profile_o),
        .timestamp_receiver_enable_o  (timestamp_receiver_enable_o),
        .timestamp_pecl_termination_o (timestamp_pecl_termination_o),
        .pll_enable_i                 (pll_enable_i),
        .reference_clock_output_en_o  (reference_clock_output_en_o)
    );
    acpcr_host host (.core_clk_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
    initial forever #2.5 core_clk_i = ~core_clk_i;
    task automatic cmp(input logic [23:0] got, input int exp);
        comparisons++;
        if (got !== exp[23:0]) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp[23:0]);
        end
    endtask
    function automatic int exp_profile(input int code);
        if (code == 'h46) return ACPCR_PROF_LOW_POWER;
        if (code == 'h4b) return ACPCR_PROF_HIGH_PERF;
        return ACPCR_PROF_RESERVED;
    endfunction
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic op(input logic w, input int a);
        host.xfer(w, a[7:0], 8'($urandom), q);
        if (w && a > 'h2e && m.exists(a)) m[a] = q;
        if (!w) cmp(q, m.exists(a) ? m[a] : 0);
        if (!w && a == 'h2c) sysref_delay_select_i = q[3:0];
        @(negedge core_clk_i);
        cmp(full_scale_setting_o, m['h31] * 256 + m['h30]);
        cmp(power_profile_code_o, m['h37]);
        cmp(power_profile_o, exp_profile(m['h37]));
        cmp({timestamp_pecl_termination_o, timestamp_receiver_enable_o}, m['h3b]);
        cmp(reference_clock_output_en_o, m['h3c] & pll_enable_i);
        cmp(capture_delay_o, sysref_delay_select_i);
    endtask
    initial begin
        void'($urandom(13));
        m = '{'h2c: 0, 'h2d: 0, 'h2e: 0, 'h30: 0, 'h31: 'ha0, 'h37: 'h4b, 'h3b: 0, 'h3c: 1};
        repeat (6) @(negedge core_clk_i);
        rstn_i = 1;
        for (int a = 'h2c; a <= 'h40; a++) op(0, a);
        repeat (300) begin
            pos_valid_i = $urandom_range(3) == 0;
            pos_value_i = 24'($urandom);
            pll_enable_i = 1'($urandom);
            if (pos_valid_i) begin
                m['h2c] = pos_value_i[7:0];
                m['h2d] = pos_value_i[15:8];
                m['h2e] = pos_value_i[23:16];
            end
            @(negedge core_clk_i);
            pos_valid_i = 0;
            op(1'($urandom_range(1)), 'h2c + int'($urandom_range(20)));
        end
        give_verdict();
    end
endmodule
